// File: cfs_supervisor.sv
// Converter fault supervisor: qualifies overload, thermal and supply
// faults and gates the switching enable, soft start and recharge.
// Assumes comparator outputs arrive asynchronously as levels.
//
// Functional notes
// - Halt switching after feedback, once above the upper threshold, stays above the lower threshold for the full qualify time.
// - Clear the qualify timer whenever feedback drops below the lower threshold.
// - Keep switching while the qualify timer counts, stop only at expiry.
// - At startup begin only once feedback has reached the upper threshold.
// - After an overload stop wait the restart interval from the halt, then soft start.
// - A persisting overload halts again one qualify time after restart, repeating forever.
// - While overload halted, enable recharge when supply falls below the low level.
// - While overload halted, disable recharge once supply rises above the high level.
// - Over-temperature is filtered by a timer and then latches switching off.
// - Undervoltage, overvoltage and sense short faults recover once they clear.
// - An open sense input stops switching and recovers once it clears.
// - Supply below the off threshold forces the off state over everything else.
`timescale 1ns/1ns
`default_nettype none
module cfs_supervisor #(
    // Timer lengths in clock cycles; defaults are the product values
    parameter longint unsigned QUALIFY_CYCLES =
        cfs_pkg::OVERLOAD_QUALIFY_CYCLES,
    parameter longint unsigned RESTART_CYCLES =
        cfs_pkg::RESTART_WAIT_CYCLES,
    parameter longint unsigned FILTER_CYCLES =
        cfs_pkg::THERMAL_FILTER_CYCLES,
    parameter longint unsigned SOFT_CYCLES = cfs_pkg::SOFT_START_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire cfs_pkg::cfs_comp_t comp_in,
    output cfs_pkg::cfs_out_t ctrl_out
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    cfs_pkg::cfs_regs_t st_r;
    cfs_pkg::cfs_regs_t st_nxt;
    localparam logic [cfs_pkg::TIMER_W-1:0] OLP_LAST =
        cfs_pkg::TIMER_W'(QUALIFY_CYCLES - 1);
    localparam logic [cfs_pkg::TIMER_W-1:0] WAIT_LAST =
        cfs_pkg::TIMER_W'(RESTART_CYCLES - 1);
    localparam logic [cfs_pkg::TIMER_W-1:0] TSD_LAST =
        cfs_pkg::TIMER_W'(FILTER_CYCLES - 1);
    localparam logic [cfs_pkg::TIMER_W-1:0] SOFT_LAST =
        cfs_pkg::TIMER_W'(SOFT_CYCLES - 1);
    localparam logic [cfs_pkg::TIMER_W-1:0] CNT_ONE =
        cfs_pkg::TIMER_W'(1);
    localparam logic [cfs_pkg::TIMER_W-1:0] CNT_ZERO = '0;

    // Faults that stop switching and recover on their own
    function automatic logic auto_fault(input cfs_pkg::cfs_comp_t c);
        auto_fault = c.supply_uvlo | c.supply_overvoltage_guard |
                     c.sense_short | c.sense_open;
    endfunction

    cfs_pkg::cfs_comp_t c;
    logic olp_expired;
    assign c = st_r.sync2;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        olp_expired = 1'b0;
        st_nxt.sync1 = comp_in;
        st_nxt.sync2 = st_r.sync1;

        // Thermal filter runs in every state
        if (c.thermal_shutdown) begin
            if (st_r.tsd_cnt != TSD_LAST) begin
                st_nxt.tsd_cnt = st_r.tsd_cnt + CNT_ONE;
            end
        end else begin
            st_nxt.tsd_cnt = CNT_ZERO;
        end

        // Overload qualify timer with hysteresis
        if (st_r.state == cfs_pkg::ST_RUN ||
                st_r.state == cfs_pkg::ST_SOFT) begin
            if (c.fb_below_lower) begin
                st_nxt.olp_armed = 1'b0;
                st_nxt.olp_cnt = CNT_ZERO;
            end else if (c.fb_above_upper || st_r.olp_armed) begin
                st_nxt.olp_armed = 1'b1;
                if (st_r.olp_cnt == OLP_LAST) begin
                    olp_expired = 1'b1;
                end else begin
                    st_nxt.olp_cnt = st_r.olp_cnt + CNT_ONE;
                end
            end
        end else begin
            st_nxt.olp_armed = 1'b0;
            st_nxt.olp_cnt = CNT_ZERO;
        end

        case (st_r.state)
            cfs_pkg::ST_OFF: begin
                st_nxt.wait_cnt = CNT_ZERO;
                if (!auto_fault(c)) begin
                    st_nxt.state = cfs_pkg::ST_WAIT_FB;
                end
            end
            cfs_pkg::ST_WAIT_FB: begin
                if (auto_fault(c)) begin
                    st_nxt.state = cfs_pkg::ST_OFF;
                end else if (c.fb_above_upper) begin
                    st_nxt.state = cfs_pkg::ST_SOFT;
                    st_nxt.wait_cnt = CNT_ZERO;
                end
            end
            cfs_pkg::ST_SOFT, cfs_pkg::ST_RUN: begin
                if (auto_fault(c)) begin
                    st_nxt.state = cfs_pkg::ST_OFF;
                end else if (olp_expired) begin
                    st_nxt.state = cfs_pkg::ST_OLP_HALT;
                    st_nxt.wait_cnt = CNT_ZERO;
                end else if (st_r.state == cfs_pkg::ST_SOFT) begin
                    if (st_r.wait_cnt == SOFT_LAST) begin
                        st_nxt.state = cfs_pkg::ST_RUN;
                    end else begin
                        st_nxt.wait_cnt = st_r.wait_cnt + CNT_ONE;
                    end
                end
            end
            cfs_pkg::ST_OLP_HALT: begin
                if (st_r.wait_cnt == WAIT_LAST) begin
                    st_nxt.state = cfs_pkg::ST_SOFT;
                    st_nxt.wait_cnt = CNT_ZERO;
                end else begin
                    st_nxt.wait_cnt = st_r.wait_cnt + CNT_ONE;
                end
            end
            cfs_pkg::ST_LATCH: begin
                st_nxt.state = cfs_pkg::ST_LATCH;
            end
            default: begin
                st_nxt.state = cfs_pkg::ST_OFF;
            end
        endcase

        // Thermal latch beats all but the supply off level
        if (st_r.tsd_cnt == TSD_LAST && c.thermal_shutdown) begin
            st_nxt.state = cfs_pkg::ST_LATCH;
        end

        // Supply below off level overrides every mode
        if (c.supply_below_off) begin
            st_nxt.state = cfs_pkg::ST_OFF;
            st_nxt.olp_armed = 1'b0;
            st_nxt.olp_cnt = CNT_ZERO;
            st_nxt.wait_cnt = CNT_ZERO;
            st_nxt.tsd_cnt = CNT_ZERO;
        end

        // Recharge hysteresis only in overload halt
        if (st_nxt.state == cfs_pkg::ST_OLP_HALT) begin
            if (c.supply_below_recharge_low) begin
                st_nxt.out.recharge_enable = 1'b1;
            end else if (c.supply_above_recharge_high) begin
                st_nxt.out.recharge_enable = 1'b0;
            end
        end else begin
            st_nxt.out.recharge_enable = 1'b0;
        end

        st_nxt.out.switch_enable =
            (st_nxt.state == cfs_pkg::ST_SOFT) ||
            (st_nxt.state == cfs_pkg::ST_RUN);
        st_nxt.out.soft_start = (st_nxt.state == cfs_pkg::ST_SOFT);
        st_nxt.out.overload_halted =
            (st_nxt.state == cfs_pkg::ST_OLP_HALT);
        st_nxt.out.thermal_latched = (st_nxt.state == cfs_pkg::ST_LATCH);
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_r <= '0;
            st_r.state <= cfs_pkg::ST_OFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ctrl_out = st_r.out;

endmodule
`default_nettype wire

// File: cfs_pkg.sv
// Package for the converter fault supervisor: timing constants,
// comparator input bundle, output bundle and state encoding.
// Assumes a single 125 MHz system clock.
package cfs_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned OVERLOAD_QUALIFY_TIME_MS = 64;
    localparam int unsigned RESTART_WAIT_INTERVAL_MS = 512;
    localparam int unsigned THERMAL_FILTER_TIME_US = 100;
    localparam int unsigned SOFT_START_TIME_US = 1000;
    localparam longint unsigned OVERLOAD_QUALIFY_CYCLES =
        longint'(CLK_HZ) * OVERLOAD_QUALIFY_TIME_MS / 1000;
    localparam longint unsigned RESTART_WAIT_CYCLES =
        longint'(CLK_HZ) * RESTART_WAIT_INTERVAL_MS / 1000;
    localparam longint unsigned THERMAL_FILTER_CYCLES =
        longint'(CLK_HZ) * THERMAL_FILTER_TIME_US / 1000000;
    localparam longint unsigned SOFT_START_CYCLES =
        longint'(CLK_HZ) * SOFT_START_TIME_US / 1000000;
    localparam int TIMER_W = 32;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic fb_above_upper;
        logic fb_below_lower;
        logic supply_below_off;
        logic supply_uvlo;
        logic supply_overvoltage_guard;
        logic supply_below_recharge_low;
        logic supply_above_recharge_high;
        logic sense_open;
        logic sense_short;
        logic thermal_shutdown;
    } cfs_comp_t;

    typedef struct packed {
        logic switch_enable;
        logic soft_start;
        logic recharge_enable;
        logic overload_halted;
        logic thermal_latched;
    } cfs_out_t;

    typedef enum logic [5:0] {
        ST_OFF      = 6'h01,
        ST_WAIT_FB  = 6'h02,
        ST_SOFT     = 6'h04,
        ST_RUN      = 6'h08,
        ST_OLP_HALT = 6'h10,
        ST_LATCH    = 6'h20
    } cfs_state_t;

    typedef struct packed {
        cfs_comp_t sync1;
        cfs_comp_t sync2;
        cfs_state_t state;
        logic [TIMER_W-1:0] olp_cnt;
        logic [TIMER_W-1:0] wait_cnt;
        logic [TIMER_W-1:0] tsd_cnt;
        logic olp_armed;
        cfs_out_t out;
    } cfs_regs_t;

endpackage

// File: cfs_supervisor_sva.sv
// Checker on the fault supervisor ports.
// Assumes binding to cfs_supervisor.
`timescale 1ns/1ns
`default_nettype none
module cfs_supervisor_sva (
    input wire logic clk_sys,
    input wire logic reset,
    input wire cfs_pkg::cfs_comp_t comp_in,
    input wire cfs_pkg::cfs_out_t ctrl_out
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_off_forces: assert property (
        comp_in.supply_below_off [*3] |=> ctrl_out == 5'h00)
        else $error("outputs not off under low supply");
    a_open_stops: assert property (
        comp_in.sense_open [*3] |=> !ctrl_out.switch_enable)
        else $error("switching with open sense");
    a_auto_stops: assert property (
        (comp_in.supply_uvlo || comp_in.supply_overvoltage_guard
        || comp_in.sense_short) [*3] |=> !ctrl_out.switch_enable)
        else $error("switching with supply or short fault");
    a_recharge_halt: assert property (
        ctrl_out.recharge_enable |-> ctrl_out.overload_halted)
        else $error("recharge outside overload halt");
    a_latch_off: assert property (
        ctrl_out.thermal_latched |-> !ctrl_out.switch_enable)
        else $error("switching while thermal latched");
    a_latch_holds: assert property (
        (!comp_in.supply_below_off [*3] ##0 ctrl_out.thermal_latched)
        |=> ctrl_out.thermal_latched)
        else $error("thermal latch released");
    a_filter_held: assert property (
        $rose(ctrl_out.thermal_latched) |->
        $past(comp_in.thermal_shutdown, 3) &&
        $past(comp_in.thermal_shutdown, 9))
        else $error("thermal latch without filtering");
    a_start_gate: assert property (
        $rose(ctrl_out.switch_enable) && !$past(ctrl_out.overload_halted)
        |-> $past(comp_in.fb_above_upper, 3))
        else $error("start without feedback above upper");
    a_sync_delay: assert property (
        ctrl_out.switch_enable && $rose(comp_in.supply_below_off)
        |=> ctrl_out.switch_enable [*2])
        else $error("fault acted before synchroniser");
endmodule
`default_nettype wire

// File: cfs_fb_model.sv
// Feedback optocoupler model: load level to feedback comparators.
// Assumes load_lvl 0 light, 1 between thresholds, 2 heavy.
`timescale 1ns/1ns
`default_nettype none
module cfs_fb_model (
    input wire logic [1:0] load_lvl,
    output logic fb_above,
    output logic fb_below
);
    // Heavy load lifts feedback, light load pulls it down
    assign fb_above = (load_lvl == 2'h2);
    assign fb_below = (load_lvl == 2'h0);
endmodule
`default_nettype wire

// File: converter_fault_supervisor_tb.sv
// Testbench for the converter fault supervisor.
// Assumes the checker and feedback model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module converter_fault_supervisor_tb;
    typedef struct {
        cfs_pkg::cfs_comp_t f;
        cfs_pkg::cfs_out_t o;
    } cfs_row_t;
    logic clk_sys;
    logic reset;
    logic [1:0] load_lvl;
    logic fb_above;
    logic fb_below;
    cfs_pkg::cfs_comp_t faults;
    cfs_pkg::cfs_comp_t comp_in;
    cfs_pkg::cfs_out_t ctrl_out;
    cfs_row_t rows [7];
    int err_total;
    int check_count;
    // Short timers so that every timer expires within the run
    localparam int T_QUAL = 400;
    localparam int T_REST = 1600;
    localparam int T_FILT = 60;
    localparam int T_SOFT = 64;
    cfs_supervisor #(
        .QUALIFY_CYCLES(longint'(T_QUAL)),
        .RESTART_CYCLES(longint'(T_REST)),
        .FILTER_CYCLES(longint'(T_FILT)),
        .SOFT_CYCLES(longint'(T_SOFT))
    ) cfs_supervisor_i (.clk_sys(clk_sys), .reset(reset),
        .comp_in(comp_in), .ctrl_out(ctrl_out));
    cfs_fb_model cfs_fb_model_i (.load_lvl(load_lvl),
        .fb_above(fb_above), .fb_below(fb_below));
    always_comb begin
        comp_in = faults;
        comp_in.fb_above_upper = fb_above;
        comp_in.fb_below_lower = fb_below;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic chk(input cfs_pkg::cfs_out_t exp);
        check_count++;
        if (ctrl_out !== exp) begin
            err_total++;
            $display("Error ctrl_out exp %h got %h", exp, ctrl_out);
        end
    endtask
    task automatic give_verdict;
        $display("Checks %0d, errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        // About twice the length of the scripted run
        #80000;
        err_total++;
        give_verdict();
    end
    initial begin
        reset = 1'b1;
        load_lvl = 2'h1;
        faults = '0;
        err_total = 0;
        check_count = 0;
        rows = '{'{10'h080, 5'h00}, '{10'h040, 5'h00}, '{10'h020, 5'h00},
            '{10'h004, 5'h00}, '{10'h002, 5'h00}, '{10'h010, 5'h18},
            '{10'h008, 5'h18}};
        cyc(20);
        chk(5'h00);
        reset = 1'b0;
        cyc(10);
        chk(5'h00);
        load_lvl = 2'h2;
        cyc(2);
        chk(5'h00);
        cyc(1);
        chk(5'h18);
        load_lvl = 2'h1;
        cyc(T_SOFT - 1);
        chk(5'h18);
        cyc(1);
        chk(5'h10);
        load_lvl = 2'h2;
        $display("Startup test done");
        for (int i = 0; i < 7; i++) begin
            faults = rows[i].f;
            cyc(5);
            chk(rows[i].o);
            faults = '0;
            cyc(8);
            chk(5'h18);
            $display("Row %0d done", i);
        end
        faults.supply_below_off = 1'b1;
        cyc(2);
        chk(5'h18);
        cyc(1);
        chk(5'h00);
        faults = '0;
        cyc(8);
        chk(5'h18);
        $display("Latency test done");
        faults.thermal_shutdown = 1'b1;
        cyc(T_FILT / 2);
        faults = '0;
        cyc(8);
        chk(5'h18);
        faults.thermal_shutdown = 1'b1;
        cyc(T_FILT + 1);
        chk(5'h10);
        cyc(1);
        chk(5'h01);
        faults = '0;
        cyc(20);
        chk(5'h01);
        faults.supply_below_off = 1'b1;
        cyc(5);
        chk(5'h00);
        faults = '0;
        cyc(8);
        chk(5'h18);
        $display("Thermal test done");
        cyc(T_QUAL - 5);
        chk(5'h10);
        cyc(1);
        chk(5'h02);
        faults.supply_below_recharge_low = 1'b1;
        cyc(3);
        chk(5'h06);
        faults = '0;
        cyc(3);
        chk(5'h06);
        faults.supply_above_recharge_high = 1'b1;
        cyc(3);
        chk(5'h02);
        faults = '0;
        cyc(T_REST - 10);
        chk(5'h02);
        cyc(1);
        chk(5'h18);
        cyc(T_QUAL - 1);
        chk(5'h10);
        cyc(1);
        chk(5'h02);
        cyc(T_REST);
        chk(5'h18);
        cyc(T_QUAL / 2);
        load_lvl = 2'h0;
        cyc(4);
        load_lvl = 2'h2;
        cyc(T_QUAL / 2 - 4);
        chk(5'h10);
        cyc(T_QUAL / 2 + 5);
        chk(5'h10);
        cyc(1);
        chk(5'h02);
        $display("Overload test done");
        reset = 1'b1;
        cyc(2);
        chk(5'h00);
        reset = 1'b0;
        cyc(8);
        chk(5'h18);
        $display("Reset test done");
        give_verdict();
    end
endmodule
bind cfs_supervisor cfs_supervisor_sva cfs_supervisor_sva_i (
    .clk_sys(clk_sys), .reset(reset), .comp_in(comp_in),
    .ctrl_out(ctrl_out));
`default_nettype wire
